// file: hw/ccs_cfg_shift.sv
`timescale 1ns/1ps
module ccs_cfg_shift (
  input  wire logic               clk_sys,
  input  wire logic               arst_n,
  input  wire ccs_pkg::ccs_ser_t  ser,
  input  wire ccs_pkg::ccs_cfg_t  static_cfg,
  input  wire logic               use_dynamic,
  output ccs_pkg::ccs_cfg_t       cfg,
  output logic                    ser_dout
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]                  s1;
    logic [2:0]                  s2;
    logic [2:0]                  s3;
    logic [2:0]                  filt;
    logic [ccs_pkg::CFG_W-1:0]   shreg;
    ccs_pkg::ccs_cfg_t           shadow;
    logic                        loaded;
    ccs_pkg::ccs_cfg_t           cfg;
    logic                        dout;
  } ccs_shift_st_t;

  ccs_shift_st_t s;
  ccs_shift_st_t next_s;
  logic          clk_rise;
  logic          upd_rise;

  // ----------------------------------------------------------------
  // Serial port
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s    = s;
    next_s.s1 = {ser.ser_clk, ser.ser_data, ser.ser_update};
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    for (int i = 0; i < 3; i++)
    begin
      if (s.s2[i] == s.s3[i])
        next_s.filt[i] = s.s3[i];
    end
    clk_rise = next_s.filt[2] & ~s.filt[2];
    upd_rise = next_s.filt[0] & ~s.filt[0];
    // Shift enable comes from core logic, same clock
    if (clk_rise && ser.ser_shift)
      next_s.shreg = {s.shreg[ccs_pkg::CFG_W-2:0], next_s.filt[1]};
    // Seed shadow once after reset so a switch to dynamic is glitch free
    if (!s.loaded)
    begin
      next_s.shadow = static_cfg;
      next_s.loaded = 1'b1;
    end
    else if (upd_rise && !ser.ser_shift)
      next_s.shadow = ccs_pkg::ccs_cfg_t'(s.shreg);
    next_s.cfg  = use_dynamic ? s.shadow : static_cfg;
    next_s.dout = s.shreg[ccs_pkg::CFG_W-1];
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign cfg      = s.cfg;
  assign ser_dout = s.dout;

endmodule : ccs_cfg_shift

// file: hw/ccs_top.sv
`timescale 1ns/1ps
module ccs_top #(
  parameter int LOCK_GOOD = ccs_pkg::LOCK_GOOD
) (
  input  wire logic                  clk_sys,
  input  wire logic                  arst_n,
  input  wire ccs_pkg::ccs_pins_t    pins,
  input  wire logic [2:0]            core_in,
  input  wire logic                  pll_sleep_n,
  input  wire ccs_pkg::ccs_ser_t     ser,
  input  wire ccs_pkg::ccs_cfg_t     static_cfg,
  input  wire logic                  use_dynamic,
  output ccs_pkg::ccs_clk_out_t      clk_out,
  output logic                       pll_lock,
  output logic                       cfg_conflict,
  output logic                       ser_dout
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (LOCK_GOOD < 1 || LOCK_GOOD > 15)
    $error("ccs_top: LOCK_GOOD must lie in 1..15");
  if (ccs_pkg::DLY_TAPS != (1 << ccs_pkg::DLY_W))
    $error("ccs_top: delay taps must match select width");

  localparam logic [ccs_pkg::GOOD_W-1:0] GOOD_LIM = ccs_pkg::GOOD_W'(LOCK_GOOD);
  localparam int FX = ccs_pkg::FIXED_DLY_CYC;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ccs_pkg::N_PIN-1:0]                        s1;
    logic [ccs_pkg::N_PIN-1:0]                        s2;
    logic [ccs_pkg::N_PIN-1:0]                        s3;
    logic [ccs_pkg::N_PIN-1:0]                        filt;
    logic [ccs_pkg::N_DLY-1:0][ccs_pkg::DLY_TAPS-1:0] dl;
    logic [FX-1:0]                                    fixed;
    logic                                             ref_prev;
    logic [ccs_pkg::DIV_W-1:0]                        ref_cnt;
    logic [ccs_pkg::ACC_W-1:0]                        acc;
    logic [ccs_pkg::ACC_W-1:0]                        step;
    logic [ccs_pkg::N_DIV-2:0][ccs_pkg::DIV_W-1:0]    div_cnt;
    logic [ccs_pkg::N_DIV-2:0]                        div_out;
    logic                                             fb_prev;
    logic [ccs_pkg::EDGE_W-1:0]                       fb_edges;
    logic [ccs_pkg::GOOD_W-1:0]                       good;
    logic                                             lock;
    ccs_pkg::ccs_clk_out_t                            out;
    logic                                             conflict;
  } ccs_top_st_t;

  ccs_top_st_t       s;
  ccs_top_st_t       next_s;
  ccs_pkg::ccs_cfg_t cfg;
  logic              shift_dout;

  // ----------------------------------------------------------------
  // Dynamic configuration register
  // ----------------------------------------------------------------
  ccs_cfg_shift u_cfg_shift (
    .clk_sys     (clk_sys),
    .arst_n      (arst_n),
    .ser         (ser),
    .static_cfg  (static_cfg),
    .use_dynamic (use_dynamic),
    .cfg         (cfg),
    .ser_dout    (shift_dout)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Illegal source codes fall back to low rather than a pin
  function automatic logic src_level(
    input ccs_pkg::ccs_src_t         sel,
    input logic [ccs_pkg::N_PIN-1:0] f,
    input logic                      core
  );
    logic [ccs_pkg::N_SE-1:0]   se;
    logic [ccs_pkg::N_DIFF-1:0] dp;
    logic [ccs_pkg::N_DIFF-1:0] dn;
    {se, dp, dn} = f;
    unique case (sel)
      ccs_pkg::SRC_SE0:   src_level = se[0];
      ccs_pkg::SRC_SE1:   src_level = se[1];
      ccs_pkg::SRC_SE2:   src_level = se[2];
      ccs_pkg::SRC_DIFF0: src_level = dp[0] & ~dn[0];
      ccs_pkg::SRC_DIFF1: src_level = dp[1] & ~dn[1];
      ccs_pkg::SRC_CORE:  src_level = core;
      default:            src_level = 1'b0;
    endcase
  endfunction : src_level

  // Output select for one global output when not owned by the loop
  function automatic logic buf_level(
    input ccs_pkg::ccs_mode_t mode,
    input logic               lvl,
    input logic               tap
  );
    unique case (mode)
      ccs_pkg::MODE_BUF: buf_level = lvl;
      ccs_pkg::MODE_DLY: buf_level = tap;
      default:           buf_level = 1'b0;
    endcase
  endfunction : buf_level

  // Divider step: counts events, toggles once every div+1 of them
  function automatic logic [ccs_pkg::DIV_W:0] div_step(
    input logic [ccs_pkg::DIV_W-1:0] cnt,
    input logic [ccs_pkg::DIV_W-1:0] div,
    input logic                      tick
  );
    if (!tick)
      div_step = {1'b0, cnt};
    else if (cnt >= div)
      div_step = {1'b1, {ccs_pkg::DIV_W{1'b0}}};
    else
      div_step = {1'b0, cnt + ccs_pkg::DIV_ONE};
  endfunction : div_step

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [2:0]                lvl;
  logic [ccs_pkg::N_DLY-1:0] tap;
  logic [ccs_pkg::N_DLY-1:0] dl_in;
  logic                      loop_on;
  logic                      vco_tick;
  logic                      ref_tick;
  logic                      fb_rise;
  logic                      a_pll;
  logic                      b_busy;
  logic                      c_busy;
  logic [ccs_pkg::DIV_W:0]   dv;
  logic [ccs_pkg::DIV_W-1:0] dsel [ccs_pkg::N_DIV-2:0];

  always_comb
  begin
    next_s = s;
    // Three-stage pin filter; second and third must agree
    next_s.s1 = pins;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    for (int i = 0; i < ccs_pkg::N_PIN; i++)
    begin
      if (s.s2[i] == s.s3[i])
        next_s.filt[i] = s.s3[i];
    end
    lvl[0] = src_level(cfg.src_a, s.filt, core_in[0]);
    lvl[1] = src_level(cfg.src_b, s.filt, core_in[1]);
    lvl[2] = src_level(cfg.src_c, s.filt, core_in[2]);

    // Delay line taps: delay 0 is one cycle, each step one cycle
    for (int k = 0; k < ccs_pkg::N_DLY; k++)
      tap[k] = s.dl[k][cfg.dly[k]];

    a_pll   = (cfg.mode_a == ccs_pkg::MODE_PLL);
    loop_on = pll_sleep_n & a_pll;
    next_s.ref_prev = lvl[0];

    // Loop: phase accumulator locked to reference by edge counting
    vco_tick = 1'b0;
    ref_tick = 1'b0;
    fb_rise  = 1'b0;
    dv       = '0;
    dsel[0]  = cfg.div_a;
    dsel[1]  = cfg.div_b;
    dsel[2]  = cfg.div_c;
    dsel[3]  = cfg.div_m;
    if (!loop_on)
    begin
      // Held disabled: drop lock, restart acquisition from scratch
      next_s.acc      = '0;
      next_s.step     = ccs_pkg::STEP_INIT;
      next_s.ref_cnt  = '0;
      next_s.div_cnt  = '0;
      next_s.div_out  = '0;
      next_s.fb_edges = '0;
      next_s.good     = '0;
      next_s.lock     = 1'b0;
    end
    else
    begin
      next_s.acc = s.acc + s.step;
      vco_tick   = ~s.acc[ccs_pkg::ACC_W-1] & next_s.acc[ccs_pkg::ACC_W-1];
      // Output dividers A, B, C and feedback divider M
      for (int d = 0; d < ccs_pkg::N_DIV - 1; d++)
      begin
        dv = div_step(s.div_cnt[d], dsel[d], vco_tick);
        next_s.div_cnt[d] = dv[ccs_pkg::DIV_W-1:0];
        if (dv[ccs_pkg::DIV_W])
          next_s.div_out[d] = ~s.div_out[d];
      end
      // Reference divider N
      if (lvl[0] && !s.ref_prev)
      begin
        if (s.ref_cnt >= cfg.div_n)
        begin
          next_s.ref_cnt = '0;
          ref_tick       = 1'b1;
        end
        else
          next_s.ref_cnt = s.ref_cnt + ccs_pkg::DIV_ONE;
      end
      fb_rise = s.fixed[FX-1] & ~s.fb_prev;
      if (ref_tick)
      begin
        // Exactly one feedback edge per reference window means on frequency
        next_s.fb_edges = fb_rise ? ccs_pkg::EDGE_ONE : '0;
        if (s.fb_edges == '0)
        begin
          if (s.step < ccs_pkg::STEP_MAX)
            next_s.step = s.step + ccs_pkg::STEP_ONE;
          next_s.good = '0;
          next_s.lock = 1'b0;
        end
        else if (s.fb_edges > ccs_pkg::EDGE_ONE)
        begin
          if (s.step > ccs_pkg::STEP_MIN)
            next_s.step = s.step - ccs_pkg::STEP_ONE;
          next_s.good = '0;
          next_s.lock = 1'b0;
        end
        else if (s.good >= GOOD_LIM)
          next_s.lock = 1'b1;
        else
          next_s.good = s.good + ccs_pkg::GOOD_ONE;
      end
      else if (fb_rise && s.fb_edges != ccs_pkg::EDGE_MAX)
        next_s.fb_edges = s.fb_edges + ccs_pkg::EDGE_ONE;
    end

    // Feedback path: programmable delay then fixed delay
    next_s.fixed   = FX'({s.fixed, tap[ccs_pkg::DLY_FB]});
    next_s.fb_prev = s.fixed[FX-1];

    // Delay element inputs; buffers reuse the output delays when the loop is off
    dl_in[ccs_pkg::DLY_A]  = a_pll ? s.div_out[0] : lvl[0];
    dl_in[ccs_pkg::DLY_B]  = (a_pll && cfg.mode_b == ccs_pkg::MODE_PLL) ?
                             s.div_out[1] : lvl[1];
    dl_in[ccs_pkg::DLY_C]  = (a_pll && cfg.mode_c == ccs_pkg::MODE_PLL) ?
                             s.div_out[2] : lvl[2];
    dl_in[ccs_pkg::DLY_YB] = s.div_out[1];
    dl_in[ccs_pkg::DLY_YC] = s.div_out[2];
    dl_in[ccs_pkg::DLY_FB] = s.div_out[3];
    for (int k = 0; k < ccs_pkg::N_DLY; k++)
      next_s.dl[k] = {s.dl[k][ccs_pkg::DLY_TAPS-2:0], dl_in[k]};

    // Output routing
    b_busy = cfg.yb_en & a_pll;
    c_busy = cfg.yc_en & a_pll;
    next_s.out.global_out_a = a_pll ? tap[ccs_pkg::DLY_A] :
                     buf_level(cfg.mode_a, lvl[0], tap[ccs_pkg::DLY_A]);
    // Loop B/C need the loop on A; otherwise a spare output may buffer
    if (cfg.mode_b == ccs_pkg::MODE_PLL)
      next_s.out.global_out_b = a_pll & tap[ccs_pkg::DLY_B];
    else
      next_s.out.global_out_b = ~b_busy &
                       buf_level(cfg.mode_b, lvl[1], tap[ccs_pkg::DLY_B]);
    if (cfg.mode_c == ccs_pkg::MODE_PLL)
      next_s.out.global_out_c = a_pll & tap[ccs_pkg::DLY_C];
    else
      next_s.out.global_out_c = ~c_busy &
                       buf_level(cfg.mode_c, lvl[2], tap[ccs_pkg::DLY_C]);
    next_s.out.yb = b_busy & tap[ccs_pkg::DLY_YB];
    next_s.out.yc = c_busy & tap[ccs_pkg::DLY_YC];
    next_s.conflict =
      (b_busy && (cfg.mode_b == ccs_pkg::MODE_BUF || cfg.mode_b == ccs_pkg::MODE_DLY)) ||
      (c_busy && (cfg.mode_c == ccs_pkg::MODE_BUF || cfg.mode_c == ccs_pkg::MODE_DLY));
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s      <= '0;
      s.step <= ccs_pkg::STEP_INIT;
    end
    else
      s <= next_s;
  end

  // Serial readback is already a flop inside the shifter
  assign clk_out      = s.out;
  assign pll_lock     = s.lock;
  assign cfg_conflict = s.conflict;
  assign ser_dout     = shift_dout;

endmodule : ccs_top

// file: shared/ccs_pkg.sv
package ccs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS   = 25000;
  localparam int DLY_STEP_PS     = 200;
  localparam int FIXED_DLY_PS    = 2200;
  // Least time, rounded up, never below one cycle
  localparam int FIXED_DLY_CYC_R = (FIXED_DLY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FIXED_DLY_CYC   = (FIXED_DLY_CYC_R < 1) ? 1 : FIXED_DLY_CYC_R;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int N_OUT    = 3;
  localparam int N_SE     = 3;
  localparam int N_DIFF   = 2;
  localparam int N_PIN    = N_SE + 2 * N_DIFF;
  localparam int N_DLY    = 6;
  localparam int N_DIV    = 5;
  localparam int DLY_W    = 5;
  localparam int DLY_TAPS = 32;
  localparam int DIV_W    = 6;
  localparam int ACC_W    = 16;
  localparam int EDGE_W   = 4;
  localparam int GOOD_W   = 4;

  // ----------------------------------------------------------------
  // Delay element indices
  // ----------------------------------------------------------------
  localparam int DLY_A  = 0;
  localparam int DLY_B  = 1;
  localparam int DLY_C  = 2;
  localparam int DLY_YB = 3;
  localparam int DLY_YC = 4;
  localparam int DLY_FB = 5;

  // ----------------------------------------------------------------
  // Loop constants
  // ----------------------------------------------------------------
  localparam logic [ACC_W-1:0]  STEP_INIT = 16'h0100;
  localparam logic [ACC_W-1:0]  STEP_MAX  = 16'h7fff;
  localparam logic [ACC_W-1:0]  STEP_MIN  = 16'h0001;
  localparam logic [ACC_W-1:0]  STEP_ONE  = 16'h0001;
  localparam logic [DIV_W-1:0]  DIV_ONE   = 6'h01;
  localparam logic [EDGE_W-1:0] EDGE_ONE  = 4'h1;
  localparam logic [EDGE_W-1:0] EDGE_MAX  = 4'hf;
  localparam logic [GOOD_W-1:0] GOOD_ONE  = 4'h1;
  localparam int                LOCK_GOOD = 8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_SE0   = 3'h0,
    SRC_SE1   = 3'h1,
    SRC_SE2   = 3'h2,
    SRC_DIFF0 = 3'h3,
    SRC_DIFF1 = 3'h4,
    SRC_CORE  = 3'h5
  } ccs_src_t;

  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_BUF = 2'h1,
    MODE_DLY = 2'h2,
    MODE_PLL = 2'h3
  } ccs_mode_t;

  typedef struct packed {
    ccs_src_t                      src_a;
    ccs_src_t                      src_b;
    ccs_src_t                      src_c;
    ccs_mode_t                     mode_a;
    ccs_mode_t                     mode_b;
    ccs_mode_t                     mode_c;
    logic [N_DLY-1:0][DLY_W-1:0]   dly;
    logic [DIV_W-1:0]              div_n;
    logic [DIV_W-1:0]              div_m;
    logic [DIV_W-1:0]              div_a;
    logic [DIV_W-1:0]              div_b;
    logic [DIV_W-1:0]              div_c;
    logic                          yb_en;
    logic                          yc_en;
  } ccs_cfg_t;

  localparam int CFG_W = $bits(ccs_cfg_t);

  typedef struct packed {
    logic [N_SE-1:0]   se;
    logic [N_DIFF-1:0] diff_p;
    logic [N_DIFF-1:0] diff_n;
  } ccs_pins_t;

  typedef struct packed {
    logic ser_clk;
    logic ser_data;
    logic ser_shift;
    logic ser_update;
  } ccs_ser_t;

  typedef struct packed {
    logic global_out_a;
    logic global_out_b;
    logic global_out_c;
    logic yb;
    logic yc;
  } ccs_clk_out_t;

endpackage : ccs_pkg

// file: tb/ccs_far_model.sv
`timescale 1ns/1ps
module ccs_far_model (
  input  wire logic          clk_sys,
  input  wire logic          arst_n,
  output ccs_pkg::ccs_pins_t pins,
  output logic [2:0]         core_in
);
  // ------------------------------------------
  // One rate per source, so a wrong pick shows, except diff pair 1 and core_in[1], which share cnt[6]
  // ------------------------------------------
  logic [8:0] cnt;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      cnt <= 9'h000;
    else
      cnt <= cnt + 9'h001;
  end

  // Dedicated pins only; no routed input path modelled
  assign pins.se     = cnt[5:3];
  assign pins.diff_p = {cnt[6], cnt[2]};
  assign pins.diff_n = ~{cnt[6], cnt[2]};
  // Slowest one is the loop reference, period 512 cycles
  assign core_in     = {cnt[7], cnt[6], cnt[8]};
endmodule : ccs_far_model

// file: tb/ccs_top_asserts.sv
`timescale 1ns/1ps
module ccs_top_asserts #(
  parameter int LOCK_GOOD = 8
) (
  input wire logic                  clk_sys,
  input wire logic                  arst_n,
  input wire ccs_pkg::ccs_pins_t    pins,
  input wire logic [2:0]            core_in,
  input wire logic                  pll_sleep_n,
  input wire ccs_pkg::ccs_ser_t     ser,
  input wire ccs_pkg::ccs_cfg_t     static_cfg,
  input wire logic                  use_dynamic,
  input wire ccs_pkg::ccs_clk_out_t clk_out,
  input wire logic                  pll_lock,
  input wire logic                  cfg_conflict,
  input wire logic                  ser_dout
);
  // ------------------------------------------------------
  // Helpers; only static config is judged, shadow is hidden
  // ------------------------------------------------------
  logic       st;
  logic       pa;
  logic       ybc;
  logic       bcore;
  logic [7:0] en_cnt;

  assign st    = !use_dynamic;
  assign pa    = static_cfg.mode_a == ccs_pkg::MODE_PLL;
  assign ybc   = pa && static_cfg.yb_en;
  assign bcore = static_cfg.src_b == ccs_pkg::SRC_CORE;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      en_cnt <= 8'h00;
    else if (!pll_sleep_n)
      en_cnt <= 8'h00;
    else if (en_cnt != 8'hff)
      en_cnt <= en_cnt + 8'h01;
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  property p_sleep_drops;
    !pll_sleep_n |=> !pll_lock;
  endproperty
  a_sleep_drops: assert property (p_sleep_drops)
    else $error("lock high after sleep");
  property p_lock_run;
    $rose(pll_lock) |-> en_cnt > LOCK_GOOD;
  endproperty
  a_lock_run: assert property (p_lock_run)
    else $error("lock rose too early");
  property p_lock_loop;
    (st && !pa) [*4] |-> !pll_lock;
  endproperty
  a_lock_loop: assert property (p_lock_loop)
    else $error("lock without loop on A");
  property p_conflict;
    (st && ybc && static_cfg.mode_b inside {ccs_pkg::MODE_BUF, ccs_pkg::MODE_DLY}) [*4]
      |-> cfg_conflict && !clk_out.global_out_b;
  endproperty
  a_conflict: assert property (p_conflict)
    else $error("B buffer not refused");
  property p_no_conflict;
    (st && !static_cfg.yb_en && !static_cfg.yc_en) [*4] |-> !cfg_conflict;
  endproperty
  a_no_conflict: assert property (p_no_conflict)
    else $error("conflict without routed use");
  property p_off_low;
    (st && static_cfg.mode_a == ccs_pkg::MODE_OFF) [*4] |-> !clk_out.global_out_a;
  endproperty
  a_off_low: assert property (p_off_low)
    else $error("unused A output toggles");
  property p_buf_follow;
    (st && bcore && !ybc && static_cfg.mode_b == ccs_pkg::MODE_BUF) [*6]
      |-> clk_out.global_out_b == $past(core_in[1]);
  endproperty
  a_buf_follow: assert property (p_buf_follow)
    else $error("B buffer not one cycle behind");
  property p_dly_zero;
    (st && bcore && !ybc && static_cfg.mode_b == ccs_pkg::MODE_DLY
      && static_cfg.dly[ccs_pkg::DLY_B] == 5'h00) [*6] |-> clk_out.global_out_b == $past(core_in[1], 2);
  endproperty
  a_dly_zero: assert property (p_dly_zero)
    else $error("delay zero not two cycles");
  property p_yb_gated;
    (st && !ybc) [*4] |-> !clk_out.yb;
  endproperty
  a_yb_gated: assert property (p_yb_gated)
    else $error("routed B active while off");
  property p_ser_hold;
    (!ser.ser_shift) [*2] |=> $stable(ser_dout);
  endproperty
  a_ser_hold: assert property (p_ser_hold)
    else $error("serial out moved without shift");
endmodule : ccs_top_asserts

bind ccs_top ccs_top_asserts #(.LOCK_GOOD(LOCK_GOOD)) ccs_top_asserts_inst (
  .clk_sys(clk_sys), .arst_n(arst_n), .pins(pins), .core_in(core_in),
  .pll_sleep_n(pll_sleep_n), .ser(ser), .static_cfg(static_cfg), .use_dynamic(use_dynamic),
  .clk_out(clk_out), .pll_lock(pll_lock), .cfg_conflict(cfg_conflict), .ser_dout(ser_dout)
);

// file: tb/tb_ccs_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module tb_ccs_top;
  logic clk_sys, arst_n, pll_sleep_n, use_dyn, pll_lock, cfg_conflict, ser_dout;
  ccs_pkg::ccs_pins_t    pins;
  logic [2:0]            core_in;
  ccs_pkg::ccs_ser_t     ser;
  ccs_pkg::ccs_cfg_t     cfg;
  ccs_pkg::ccs_cfg_t     c;
  ccs_pkg::ccs_clk_out_t clk_out;
  int fail_count, num_checks, ne, no, n;
  int dv[3] = '{0, 9, 31};

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  ccs_far_model ccs_far_model_inst (.clk_sys(clk_sys), .arst_n(arst_n), .pins(pins),
    .core_in(core_in));
  ccs_top #(.LOCK_GOOD(2)) ccs_top_inst (.clk_sys(clk_sys), .arst_n(arst_n), .pins(pins),
    .core_in(core_in), .pll_sleep_n(pll_sleep_n), .ser(ser), .static_cfg(cfg),
    .use_dynamic(use_dyn), .clk_out(clk_out), .pll_lock(pll_lock),
    .cfg_conflict(cfg_conflict), .ser_dout(ser_dout));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic lvl(input logic [2:0] s);
    case (s)
      3'h0, 3'h1, 3'h2: lvl = pins.se[s];
      3'h3, 3'h4: lvl = pins.diff_p[s - 3'h3] & ~pins.diff_n[s - 3'h3];
      3'h5: lvl = core_in[0];
      default: lvl = 1'b0;
    endcase
  endfunction : lvl

  // Index 0..4 are the outputs, 5 the core B clock
  function automatic logic pick(input int i);
    logic [5:0] v;
    v = {core_in[1], clk_out.yc, clk_out.yb, clk_out.global_out_c, clk_out.global_out_b, clk_out.global_out_a};
    pick = v[i];
  endfunction : pick

  // Edge counts differ by one at most: output lags its source
  function automatic logic near(input int a, input int b);
    near = (a <= b + 1) && (b <= a + 1);
  endfunction : near

  task automatic test_done();
    if (fail_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  // A wait that runs out counts as a mismatch and ends the run
  task automatic bound(input int i, input int lim);
    if (i >= lim)
    begin
      fail_count++;
      test_done();
    end
  endtask : bound

  task automatic setc();
    @(posedge clk_sys);
    cfg <= c;
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : setc

  task automatic edges(input int p, input logic [2:0] s, input int w);
    logic ps;
    logic po;
    ne = 0;
    no = 0;
    ps = 1'b1;
    po = 1'b1;
    repeat (w)
    begin
      @(negedge clk_sys);
      if (lvl(s) === 1'b1 && ps !== 1'b1) ne++;
      if (pick(p) === 1'b1 && po !== 1'b1) no++;
      ps = lvl(s);
      po = pick(p);
    end
  endtask : edges

  task automatic lat(input int a, input int b);
    int k;
    for (k = 0; k < 3000 && pick(a) !== 1'b0; k++) @(negedge clk_sys);
    bound(k, 3000);
    for (k = 0; k < 3000 && pick(a) !== 1'b1; k++) @(negedge clk_sys);
    bound(k, 3000);
    for (n = 0; n < 100 && pick(b) !== 1'b1; n++) @(negedge clk_sys);
    bound(n, 100);
  endtask : lat

  task automatic waitlock();
    for (n = 0; n < 20000 && pll_lock !== 1'b1; n++) @(negedge clk_sys);
    bound(n, 20000);
  endtask : waitlock

  // Data held well clear of each filtered serial clock edge
  task automatic shift_cfg(input ccs_pkg::ccs_cfg_t v);
    for (int i = ccs_pkg::CFG_W - 1; i >= 0; i--)
    begin
      @(posedge clk_sys);
      ser.ser_shift <= 1'b1;
      ser.ser_data <= v[i];
      repeat (4) @(posedge clk_sys);
      ser.ser_clk <= 1'b1;
      repeat (4) @(posedge clk_sys);
      ser.ser_clk <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    ser.ser_shift <= 1'b0;
    repeat (4) @(posedge clk_sys);
    ser.ser_update <= 1'b1;
    repeat (4) @(posedge clk_sys);
    ser.ser_update <= 1'b0;
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : shift_cfg

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    fail_count = 0;
    num_checks = 0;
    arst_n = 1'b0;
    pll_sleep_n = 1'b0;
    use_dyn = 1'b0;
    ser = '0;
    cfg = '0;
    c = '0;
    repeat (12) @(posedge clk_sys);
    `CHK(pll_lock, 1'b0)
    arst_n <= 1'b1;
    c.mode_a = ccs_pkg::MODE_BUF;
    for (int s = 0; s < 8; s++)
    begin
      c.src_a = ccs_pkg::ccs_src_t'(s[2:0]);
      setc();
      edges(0, s[2:0], 1024);
      `CHK((ne > 0) ? near(ne, no) : (no == 0), 1'b1)
    end
    c.mode_a = ccs_pkg::MODE_OFF;
    setc();
    edges(0, 3'h0, 512);
    `CHK(no, 0)
    c.mode_b = ccs_pkg::MODE_BUF;
    c.src_b = ccs_pkg::SRC_CORE;
    setc();
    lat(5, 1);
    `CHK(n, 1)
    c.mode_b = ccs_pkg::MODE_DLY;
    foreach (dv[i])
    begin
      c.dly[ccs_pkg::DLY_B] = dv[i][4:0];
      setc();
      lat(5, 1);
      `CHK(n, dv[i] + 2)
    end
    c.mode_a = ccs_pkg::MODE_PLL;
    c.src_a = ccs_pkg::SRC_CORE;
    c.mode_b = ccs_pkg::MODE_BUF;
    c.yb_en = 1'b1;
    setc();
    `CHK(cfg_conflict, 1'b1)
    edges(1, 3'h5, 512);
    `CHK(no, 0)
    c.mode_b = ccs_pkg::MODE_PLL;
    c.div_b = 6'h01;
    c.mode_c = ccs_pkg::MODE_PLL;
    c.div_c = 6'h01;
    c.yc_en = 1'b1;
    setc();
    `CHK(cfg_conflict, 1'b0)
    repeat (3000) @(negedge clk_sys);
    `CHK(pll_lock, 1'b0)
    @(posedge clk_sys);
    pll_sleep_n <= 1'b1;
    waitlock();
    `CHK(pll_lock, 1'b1)
    edges(0, 3'h5, 4096);
    `CHK(near(ne, no), 1'b1)
    edges(1, 3'h5, 4096);
    `CHK(near(ne / 2, no), 1'b1)
    edges(3, 3'h5, 4096);
    `CHK(near(ne / 2, no), 1'b1)
    edges(2, 3'h5, 4096);
    `CHK(near(ne / 2, no), 1'b1)
    c.dly[ccs_pkg::DLY_B] = 5'h00;
    c.dly[ccs_pkg::DLY_YB] = 5'h07;
    c.dly[ccs_pkg::DLY_YC] = 5'h03;
    setc();
    lat(1, 3);
    `CHK(n, 7)
    lat(2, 4);
    `CHK(n, 3)
    @(posedge clk_sys);
    pll_sleep_n <= 1'b0;
    @(negedge clk_sys);
    @(negedge clk_sys);
    `CHK(pll_lock, 1'b0)
    c.div_n = 6'h01;
    c.div_m = 6'h01;
    setc();
    @(posedge clk_sys);
    pll_sleep_n <= 1'b1;
    waitlock();
    `CHK(pll_lock, 1'b1)
    edges(0, 3'h5, 4096);
    `CHK(near(ne, no), 1'b1)
    c = '0;
    c.mode_a = ccs_pkg::MODE_BUF;
    c.src_a = ccs_pkg::SRC_DIFF1;
    shift_cfg(c);
    `CHK(ser_dout, c[ccs_pkg::CFG_W - 1])
    @(posedge clk_sys);
    use_dyn <= 1'b1;
    repeat (8) @(negedge clk_sys);
    edges(0, 3'h4, 1024);
    `CHK(ne > 0 && near(ne, no), 1'b1)
    test_done();
  end
endmodule : tb_ccs_top
